// file: sac_ctrl.sv
// sac_ctrl: control of an 8-bit successive-approximation converter
// assumes: analog comparator answer is asynchronous; plain register port master on clk_sys
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl
    import sac_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  rst,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    // analog front end
    input  wire logic                  comp_above,
    output logic                       sample_hold,
    output logic      [1:0]            mux_select,
    output logic      [SAC_RES_W-1:0]  dac_code,
    output logic                       conv_clock_en,
    // shared port pins
    output logic      [SAC_CH_N-1:0]   analog_pin_enable,
    // cpu interrupt
    output logic                       conv_irq
);

////////////////////////////////////////////////////////////////////////////////
// decoding helpers

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

////////////////////////////////////////////////////////////////////////////////
// register state

    logic                  clk_sel_q,  clk_sel_d;
    logic [1:0]            chan_q,     chan_d;
    logic [SAC_CH_N-1:0]   pin_en_q,   pin_en_d;
    logic                  irq_en_q,   irq_en_d;
    logic                  flag_q,     flag_d;
    logic [SAC_PRES_W-1:0] presc_q,    presc_d;
    logic [31:0]           rdata_q,    rdata_d;
    logic                  irq_q,      irq_d;
    logic                  done;
    logic                  busy;
    logic                  start_wr;

    assign start_wr = reg_wr && hit(reg_addr, SAC_CTRL_OFS) && reg_wdata[SAC_START_BIT];

    always_comb begin
        clk_sel_d = clk_sel_q;
        chan_d    = chan_q;
        pin_en_d  = pin_en_q;
        irq_en_d  = irq_en_q;
        presc_d   = presc_q;
        flag_d    = flag_q;
        rdata_d   = 32'h0000_0000;
        if (reg_wr) begin
            if (hit(reg_addr, SAC_CTRL_OFS)) begin
                clk_sel_d = reg_wdata[SAC_CLKSEL_BIT];
                chan_d    = {reg_wdata[SAC_CHS_HI_BIT], reg_wdata[SAC_CHS_LO_BIT]};
            end
            if (hit(reg_addr, SAC_PIN_OFS)) begin
                pin_en_d = reg_wdata[SAC_CH_N-1:0];
            end
            if (hit(reg_addr, SAC_IRQEN_OFS)) begin
                irq_en_d = reg_wdata[SAC_IRQEN_BIT];
            end
            if (hit(reg_addr, SAC_PRESC_OFS)) begin
                presc_d = reg_wdata[SAC_PRES_W-1:0];
            end
            if (hit(reg_addr, SAC_FLAG_OFS) && reg_wdata[SAC_FLAG_BIT]) begin
                flag_d = 1'b0;
            end
        end
        // set beats clear in the same cycle
        if (done) begin
            flag_d = 1'b1;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                // start bit always reads zero
                SAC_CTRL_OFS:   rdata_d = {29'h0, clk_sel_q, chan_q};
                SAC_PIN_OFS:    rdata_d = {28'h0, pin_en_q};
                SAC_RESULT_OFS: rdata_d = {24'h0, dac_code};
                SAC_IRQEN_OFS:  rdata_d = {31'h0, irq_en_q};
                SAC_FLAG_OFS:   rdata_d = {31'h0, flag_q};
                SAC_PRESC_OFS:  rdata_d = {28'h0, presc_q};
                SAC_STATUS_OFS: rdata_d = {31'h0, busy};
                default:        rdata_d = 32'h0000_0000;
            endcase
        end
        irq_d = flag_d && irq_en_d;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_sel_q <= 1'b0;
            chan_q    <= 2'h0;
            pin_en_q  <= 4'h0;
            irq_en_q  <= 1'b0;
            flag_q    <= 1'b0;
            presc_q   <= SAC_PRES_RST;
            rdata_q   <= 32'h0000_0000;
            irq_q     <= 1'b0;
        end else begin
            clk_sel_q <= clk_sel_d;
            chan_q    <= chan_d;
            pin_en_q  <= pin_en_d;
            irq_en_q  <= irq_en_d;
            flag_q    <= flag_d;
            presc_q   <= presc_d;
            rdata_q   <= rdata_d;
            irq_q     <= irq_d;
        end
    end

    assign reg_rdata         = rdata_q;
    assign analog_pin_enable = pin_en_q;
    assign mux_select        = chan_q;
    assign conv_irq          = irq_q;

////////////////////////////////////////////////////////////////////////////////
// comparator synchroniser

    logic cmp_s1_q;
    logic cmp_s2_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cmp_s1_q <= 1'b0;
            cmp_s2_q <= 1'b0;
        end else begin
            cmp_s1_q <= comp_above;
            cmp_s2_q <= cmp_s1_q;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// conversion clock: prescaled or half-rate tick, only while a conversion runs

    logic [SAC_PRES_W-1:0] pdiv_q, pdiv_d;
    logic                  half_q, half_d;
    logic                  tick;
    logic                  run_q,  run_d;

    always_comb begin
        pdiv_d = pdiv_q;
        half_d = half_q;
        if (!run_q) begin
            pdiv_d = '0;
            half_d = 1'b0;
        end else begin
            half_d = ~half_q;
            pdiv_d = (pdiv_q == presc_q) ? '0 : pdiv_q + 1'b1;
        end
        tick = run_q && (clk_sel_q ? half_q : (pdiv_q == presc_q));
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pdiv_q <= '0;
            half_q <= 1'b0;
        end else begin
            pdiv_q <= pdiv_d;
            half_q <= half_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// successive-approximation sequencer

    sac_state_type         state_q, state_d;
    logic [2:0]            bit_q,   bit_d;
    logic [SAC_RES_W-1:0]  code_q,  code_d;
    logic                  done_q,  done_d;
    logic                  sh_q,    sh_d;

    always_comb begin
        state_d = state_q;
        bit_d   = bit_q;
        code_d  = code_q;
        run_d   = run_q;
        done_d  = 1'b0;
        sh_d    = 1'b0;
        unique case (state_q)
            SAC_IDLE: begin
                if (start_wr) begin
                    run_d   = 1'b1;
                    state_d = SAC_WAIT;
                end
            end
            SAC_WAIT: begin
                if (tick) begin
                    state_d = SAC_SAMPLE;
                    sh_d    = 1'b1;
                end
            end
            SAC_SAMPLE: begin
                sh_d = 1'b1;
                if (tick) begin
                    sh_d    = 1'b0;
                    state_d = SAC_CONV;
                    bit_d   = SAC_FIRST_BIT;
                    code_d  = 8'h80;
                end
            end
            SAC_CONV: begin
                if (tick) begin
                    // keep the trial bit if input is above the trial level
                    code_d[bit_q] = cmp_s2_q;
                    if (bit_q == SAC_LAST_BIT) begin
                        state_d = SAC_IDLE;
                        run_d   = 1'b0;
                        done_d  = 1'b1;
                    end else begin
                        code_d[bit_q - 3'h1] = 1'b1;
                        bit_d = bit_q - 3'h1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_q <= SAC_IDLE;
            bit_q   <= SAC_FIRST_BIT;
            code_q  <= 8'h00;
            run_q   <= 1'b0;
            done_q  <= 1'b0;
            sh_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            bit_q   <= bit_d;
            code_q  <= code_d;
            run_q   <= run_d;
            done_q  <= done_d;
            sh_q    <= sh_d;
        end
    end

    assign done          = done_q;
    assign busy          = run_q;
    assign dac_code      = code_q;
    assign sample_hold   = sh_q;
    assign conv_clock_en = run_q;

////////////////////////////////////////////////////////////////////////////////
// checks

    sequence start_s;
        state_q == SAC_IDLE && start_wr;
    endsequence

    start_run_a: assert property (@(posedge clk_sys) disable iff (rst)
        start_s |=> run_q)
        else $error("start write did not enable conversion clock");

    flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
        done |=> flag_q)
        else $error("completion flag not set after result");

    flag_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
        flag_q && !done && reg_wr && hit(reg_addr, SAC_FLAG_OFS) && !reg_wdata[0] |=> flag_q)
        else $error("writing zero changed completion flag");

    flag_clr_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && hit(reg_addr, SAC_FLAG_OFS) && reg_wdata[0] && !done |=> !flag_q)
        else $error("writing one did not clear completion flag");

    irq_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
        conv_irq |-> $past(flag_d) && $past(irq_en_d))
        else $error("interrupt raised while masked or flag clear");

    start_read_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_rd && hit(reg_addr, SAC_CTRL_OFS) |=> reg_rdata[SAC_START_BIT] == 1'b0)
        else $error("start bit read as one");

    conv_len_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == SAC_CONV && tick && bit_q == SAC_FIRST_BIT |=> state_q == SAC_CONV)
        else $error("conversion ended before eight decisions");

    samp_after_a: assert property (@(posedge clk_sys) disable iff (rst)
        state_q == SAC_WAIT && tick |=> sample_hold)
        else $error("sampling did not begin one conversion clock after start");

    chan_route_a: assert property (@(posedge clk_sys) disable iff (rst)
        reg_wr && hit(reg_addr, SAC_CTRL_OFS) |=> mux_select == $past(reg_wdata[1:0]))
        else $error("channel select not routed");

endmodule : sac_ctrl
`default_nettype wire

// file: sac_pkg.sv
// sac_pkg: constants for the successive-approximation converter control
// assumes: 32-bit plain register port, one clock clk_sys at 200 MHz
package sac_pkg;
    // register offsets (byte addresses)
    localparam logic [7:0] SAC_CTRL_OFS    = 8'h00;
    localparam logic [7:0] SAC_PIN_OFS     = 8'h04;
    localparam logic [7:0] SAC_RESULT_OFS  = 8'h08;
    localparam logic [7:0] SAC_IRQEN_OFS   = 8'h0c;
    localparam logic [7:0] SAC_FLAG_OFS    = 8'h10;
    localparam logic [7:0] SAC_PRESC_OFS   = 8'h14;
    localparam logic [7:0] SAC_STATUS_OFS  = 8'h18;
    // register fields
    localparam int SAC_CHS_LO_BIT = 0;
    localparam int SAC_CHS_HI_BIT = 1;
    localparam int SAC_CLKSEL_BIT = 2;
    localparam int SAC_START_BIT  = 3;
    localparam int SAC_FLAG_BIT   = 0;
    localparam int SAC_IRQEN_BIT  = 0;
    localparam int SAC_BUSY_BIT   = 0;
    // widths and reset values
    localparam int SAC_RES_W   = 8;
    localparam int SAC_CH_N    = 4;
    localparam int SAC_PRES_W  = 4;
    localparam logic [3:0] SAC_PRES_RST = 4'h0;
    localparam logic [2:0] SAC_LAST_BIT = 3'h0;
    localparam logic [2:0] SAC_FIRST_BIT = 3'h7;
    // state machine
    typedef enum logic [1:0] {
        SAC_IDLE   = 2'b00,
        SAC_WAIT   = 2'b01,
        SAC_SAMPLE = 2'b10,
        SAC_CONV   = 2'b11
    } sac_state_type;
endpackage : sac_pkg

// file: sac_afe_model.sv
// sac_afe_model: analog front end (sample/hold, multiplexer, comparator)
// assumes: pin levels in whole codes, each lying half a code above its value
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model (
    // clock
    input  wire logic        clk_sys,
    // from the control block
    input  wire logic        sample_hold,
    input  wire logic [1:0]  mux_select,
    input  wire logic [7:0]  dac_code,
    input  wire logic [3:0]  analog_pin_enable,
    // analog levels of the four shared pins
    input  wire logic [31:0] pin_level,
    // comparator answer
    output logic             comp_above
);
    logic [7:0] held_q;
    logic       valid_q = 1'b0;
    logic       junk_q  = 1'b0;

    // plain always: valid_q and junk_q start from declaration values, held_q has none; no reset pin
    always @(posedge clk_sys) begin
        junk_q <= ~junk_q;
        if (sample_hold) begin
            held_q  <= pin_level[mux_select*8 +: 8];
            valid_q <= analog_pin_enable[mux_select];
        end
    end

    // pin left as port: comparator sees noise, never a stale answer
    assign comp_above = valid_q ? (held_q >= dac_code) : junk_q;
endmodule : sac_afe_model
`default_nettype wire

// file: sac_ctrl_tb_top.sv
// sac_ctrl_tb_top: self-checking bench for the converter control
// assumes: sac_pkg, sac_ctrl and sac_afe_model compiled before this file
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_tb_top;
    import sac_pkg::*;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        comp_above, sample_hold, conv_clock_en, conv_irq;
    logic [1:0]  mux_select;
    logic [7:0]  dac_code;
    logic [3:0]  analog_pin_enable;
    logic [31:0] pin_level = 32'h0;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          exp_q[$];

    sac_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_above(comp_above),
        .sample_hold(sample_hold), .mux_select(mux_select), .dac_code(dac_code),
        .conv_clock_en(conv_clock_en), .analog_pin_enable(analog_pin_enable), .conv_irq(conv_irq));
    sac_afe_model afe (.clk_sys(clk_sys), .sample_hold(sample_hold), .mux_select(mux_select),
        .dac_code(dac_code), .analog_pin_enable(analog_pin_enable), .pin_level(pin_level),
        .comp_above(comp_above));

    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp, "register read");
    endtask : reg_read

    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////
    // one conversion; cs=1 skips the code check: osc/2 ticks outrun the comparator sync
    task automatic run_conv(input int ch, input int cs, input int ps, input int ien);
        int p, n, t_s, t_sh, t_end, lvl;
        p = cs ? 2 : ps + 1;
        lvl = $urandom_range(255, 0);
        pin_level[ch*8 +: 8] <= lvl[7:0];
        exp_q.push_back(lvl);
        reg_write(SAC_PRESC_OFS, ps);
        reg_write(SAC_IRQEN_OFS, ien);
        reg_write(SAC_CTRL_OFS, 32'h8 | (cs << 2) | ch);
        n = 0; t_s = -1; t_sh = -1; t_end = -1;
        // settings stay untouched until the clock stops
        while (n < 600 && t_end < 0) begin
            @(posedge clk_sys);
            #1 n++;
            if (sample_hold && t_s < 0) t_s = n;
            if (t_s >= 0 && t_sh < 0 && !sample_hold) begin
                t_sh = n - t_s;
                pin_level <= $urandom;
            end
            if (t_s >= 0 && !conv_clock_en) t_end = n;
        end
        lvl = exp_q.pop_front();
        chk(mux_select, ch, "channel route");
        chk(t_s >= 1 && t_s <= p + 2, 1, "sampling start");
        chk(t_sh, p, "sampling length");
        chk(t_end - t_s - t_sh >= 8 * p && t_end - t_s - t_sh <= 8 * p + 2, 1, "decision span");
        repeat (3) @(posedge clk_sys);
        #1 chk(conv_irq, ien, "irq level");
        if (cs == 0) begin
            chk(dac_code, lvl, "code out");
            reg_read(SAC_RESULT_OFS, lvl);
        end
        reg_read(SAC_FLAG_OFS, 1);
        reg_read(SAC_CTRL_OFS, (cs << 2) | ch);
    endtask : run_conv

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(5 * 40000);
        error_cnt++;
        tally_and_finish;
    end

    initial begin
        static logic [7:0] offs [7] = '{SAC_CTRL_OFS, SAC_PIN_OFS, SAC_IRQEN_OFS, SAC_FLAG_OFS,
                                 SAC_PRESC_OFS, SAC_STATUS_OFS, 8'h1c};
        int pe;
        void'($urandom(32'he1f9c9b5));
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        #1 chk(analog_pin_enable, 4'h0, "pins after reset");
        reg_write(8'h1c, $urandom);
        foreach (offs[i]) reg_read(offs[i], 32'h0);
        for (int i = 0; i < 3; i++) begin
            pe = $urandom_range(15, 0);
            reg_write(SAC_PIN_OFS, pe);
            #1 chk(analog_pin_enable, pe, "pin enables");
            reg_read(SAC_PIN_OFS, pe);
        end
        reg_write(SAC_PIN_OFS, 32'hf);
        for (int i = 0; i < 8; i++) begin
            run_conv(i % 4, i / 6, $urandom_range(15, 2), i % 2);
            reg_write(SAC_FLAG_OFS, 32'h0);
            reg_read(SAC_FLAG_OFS, 1);
            reg_write(SAC_IRQEN_OFS, 32'h1);
            @(posedge clk_sys);
            #1 chk(conv_irq, 1, "irq on enable");
            reg_write(SAC_FLAG_OFS, 32'h1);
            #1 chk(conv_irq, 0, "irq after clear");
            reg_read(SAC_FLAG_OFS, 0);
        end
        tally_and_finish;
    end
endmodule : sac_ctrl_tb_top
`default_nettype wire
